// [rtl/atqb_pkg.sv]
// How it works
// - The family byte is matched nibble by nibble, and a zero nibble matches anything.
// - Parameter bits 7-5 are reserved, and the card ignores them.
// - Parameter bit 4 never selects a longer answer; the answer is always standard length.
// - Every slot code in parameter bits 2-0 counts as one slot, so the card answers at once.
// - Bit 3 clear is the idle query; bit 3 set is the wake-up, taken when halted or idle.
// - The four application-data bytes of the answer are zero.
// - The first info byte is 0x91, giving 106 and 212 kbit/s with the same rate both ways.
// - The second info byte is 0x81, and its upper nibble declares a 256-byte frame.
// - The lower nibble of the second info byte is 0001b, for the block transmission protocol.
// - The upper nibble of the third info byte carries the frame waiting time integer.
// - Bits 3-2 of the third info byte are 00b, meaning proprietary application data.
// - Bits 1-0 of the third info byte are 00b, meaning no node or card numbering.
package atqb_pkg;
   localparam logic [7:0] CMD_REQ = 8'h05;
   localparam logic [7:0] RSP_CODE = 8'h50;
   localparam logic [7:0] INFO1 = 8'h91;
   localparam logic [7:0] INFO2 = 8'h81;
   localparam logic [1:0] INFO3_ADC = 2'h0;
   localparam logic [1:0] INFO3_FO = 2'h0;
   localparam logic [7:0] APP_DATA = 8'h00;
   localparam int PARAM_WAKE_BIT = 3;
   localparam logic [3:0] REQ_LEN = 4'h5;
   localparam logic [3:0] AFI_POS = 4'h1;
   localparam logic [3:0] PARAM_POS = 4'h2;
   localparam logic [3:0] RX_CNT_MAX = 4'hf;
   localparam logic [3:0] RSP_LEN = 4'hc;
   // Card state as seen by this responder
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_READY = 2'b01,
      ST_HALT = 2'b10
   } card_e;
   // One received byte with its framing marks
   typedef struct packed {
      logic valid;
      logic sof;
      logic eof;
      logic crc_ok;
      logic [7:0] data;
   } rx_byte_s;
   // One transmitted byte with its framing marks
   typedef struct packed {
      logic valid;
      logic last;
      logic [7:0] data;
   } tx_byte_s;
endpackage

// [rtl/atqb_rom.sv]
`timescale 1ns/1ps
`default_nettype none
// Answer byte picked by index, check bytes added by the modem
module atqb_rom (
   input wire logic [3:0] idx,
   input wire logic [31:0] card_id,
   input wire logic [3:0] fwi,
   output logic [7:0] data
);
   always_comb begin
      case (idx)
         4'h0: data = atqb_pkg::RSP_CODE;
         4'h1: data = card_id[31:24];
         4'h2: data = card_id[23:16];
         4'h3: data = card_id[15:8];
         4'h4: data = card_id[7:0];
         4'h5, 4'h6, 4'h7, 4'h8: data = atqb_pkg::APP_DATA;
         4'h9: data = atqb_pkg::INFO1;
         4'ha: data = atqb_pkg::INFO2;
         4'hb: data = {fwi, atqb_pkg::INFO3_ADC, atqb_pkg::INFO3_FO};
         default: data = 8'h00;
      endcase
   end
endmodule
`default_nettype wire

// [rtl/atqb_responder.sv]
`timescale 1ns/1ps
`default_nettype none
// Decodes request frames byte by byte and streams the fixed answer.
// Reply timing and the reader's guard time are the modem's business.
// Check bytes are counted here, not computed; the modem flags them.
// Ready is left only by a halt; later commands belong to other logic.
// Rates, frame size and option bits are fixed, so nothing sets them.
module atqb_responder #(
   parameter logic [7:0] FAMILY = 8'h00
) (
   input wire logic clk,
   input wire logic rst,
   input wire atqb_pkg::rx_byte_s rx,
   input wire logic tx_ready,
   input wire logic [31:0] card_id,
   input wire logic [3:0] fwi,
   input wire logic halt_req,
   output atqb_pkg::tx_byte_s tx,
   output logic busy,
   output logic [1:0] card_state
);
   logic [3:0] rx_cnt_ff, nxt_rx_cnt;
   logic [7:0] afi_ff, nxt_afi;
   logic [7:0] par_ff, nxt_par;
   logic ok_ff, nxt_ok;
   logic send_ff, nxt_send;
   logic [3:0] tx_idx_ff, nxt_tx_idx;
   atqb_pkg::card_e st_ff, nxt_st;
   atqb_pkg::tx_byte_s tx_ff, nxt_tx;
   logic [7:0] rom_data;
   logic accept;
   // Decode and handshake terms
   logic afi_hit;
   logic wake_req;
   logic frame_end;
   logic frame_good;
   logic start;
   logic take_byte;
   logic load_byte;

   // One nibble of the family byte; zero acts as a wildcard
   function automatic logic nib_match(input logic [3:0] a, input logic [3:0] own);
      nib_match = (a == 4'h0) || (a == own);
   endfunction

   // Both nibbles must pass
   function automatic logic afi_match(input logic [7:0] a, input logic [7:0] own);
      logic hi, lo;
      hi = nib_match(a[7:4], own[7:4]);
      lo = nib_match(a[3:0], own[3:0]);
      afi_match = hi && lo;
   endfunction

   // Final answer byte, shared by marking and stopping
   function automatic logic is_last(input logic [3:0] idx);
      is_last = (idx == atqb_pkg::RSP_LEN - 4'h1);
   endfunction

   // Answer table, indexed by the byte count
   atqb_rom u_rom (
      .idx(tx_idx_ff),
      .card_id(card_id),
      .fwi(fwi),
      .data(rom_data)
   );

   // Bits 7-4 and 2-0 of the parameter are never looked at
   always_comb begin
      afi_hit = afi_match(afi_ff, FAMILY);
      wake_req = par_ff[atqb_pkg::PARAM_WAKE_BIT];
      accept = 1'b0;
      if (afi_hit) begin
         // Halted card answers the wake-up form only
         if (st_ff == atqb_pkg::ST_HALT) begin
            accept = wake_req;
         end else begin
            accept = 1'b1;
         end
      end
   end

   // Frame position and opener check
   always_comb begin
      nxt_rx_cnt = rx_cnt_ff;
      nxt_ok = ok_ff;
      if (rx.valid && !send_ff) begin
         // A start byte always restarts the count
         if (rx.sof) begin
            nxt_rx_cnt = 4'h1;
            nxt_ok = (rx.data == atqb_pkg::CMD_REQ);
         end else if (rx_cnt_ff != 4'h0) begin
            nxt_rx_cnt = rx_cnt_ff + 4'h1;
            if (rx_cnt_ff == atqb_pkg::RX_CNT_MAX) begin
               nxt_ok = 1'b0; // Overlong, never a request
            end
         end
         // End mark closes the frame whatever its length
         if (rx.eof) begin
            nxt_rx_cnt = 4'h0;
         end
      end
   end

   // Family and parameter bytes at fixed positions
   // Bytes that arrive during an answer are dropped, not queued
   always_comb begin
      nxt_afi = afi_ff;
      nxt_par = par_ff;
      if (rx.valid && !send_ff && !rx.sof) begin
         case (rx_cnt_ff)
            atqb_pkg::AFI_POS: begin
               nxt_afi = rx.data;
            end
            atqb_pkg::PARAM_POS: begin
               nxt_par = rx.data;
            end
            default: begin
               nxt_par = par_ff;
            end
         endcase
      end
   end

   // Frame position registers
   always_ff @(posedge clk) begin
      if (rst) begin
         rx_cnt_ff <= 4'h0;
         ok_ff <= 1'b0;
      end else begin
         rx_cnt_ff <= nxt_rx_cnt;
         ok_ff <= nxt_ok;
      end
   end

   // Request field registers
   always_ff @(posedge clk) begin
      if (rst) begin
         afi_ff <= 8'h00;
         par_ff <= 8'h00;
      end else begin
         afi_ff <= nxt_afi;
         par_ff <= nxt_par;
      end
   end

   // Frame end and verdict; a bad check or a short frame leaves no trace
   // Length includes the final byte, not yet in the counter
   always_comb begin
      frame_end = rx.valid && rx.eof && !send_ff;
      frame_good = ok_ff && rx.crc_ok && (rx_cnt_ff + 4'h1 == atqb_pkg::REQ_LEN);
      start = frame_end && frame_good && accept && !halt_req;
   end

   // Modem handshake, at most one byte in flight
   always_comb begin
      take_byte = tx_ff.valid && tx_ready;
      load_byte = send_ff && (!tx_ff.valid || tx_ready);
   end

   // Card state; halt is taken at once, even mid-answer
   always_comb begin
      nxt_st = st_ff;
      if (halt_req) begin
         nxt_st = atqb_pkg::ST_HALT;
      end else if (start) begin
         nxt_st = atqb_pkg::ST_READY;
      end
   end

   // Card state register
   always_ff @(posedge clk) begin
      if (rst) begin
         st_ff <= atqb_pkg::ST_IDLE;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // Answer sequencing; an answer once started always runs to its end
   always_comb begin
      nxt_send = send_ff;
      nxt_tx_idx = tx_idx_ff;
      nxt_tx = tx_ff;
      // Byte taken by the modem
      if (take_byte) begin
         nxt_tx.valid = 1'b0;
      end
      // Frame accepted; first byte is loaded next cycle and shows on tx the cycle after
      if (start) begin
         nxt_send = 1'b1;
         nxt_tx_idx = 4'h0;
      end
      // Next byte loaded in the cycle the modem takes the previous one, or at once if none is waiting
      if (load_byte) begin
         nxt_tx.valid = 1'b1;
         nxt_tx.data = rom_data;
         nxt_tx.last = is_last(tx_idx_ff);
         nxt_tx_idx = tx_idx_ff + 4'h1;
         if (is_last(tx_idx_ff)) begin
            nxt_send = 1'b0;
         end
      end
   end

   // Answer registers
   always_ff @(posedge clk) begin
      if (rst) begin
         send_ff <= 1'b0;
         tx_idx_ff <= 4'h0;
         tx_ff <= '0;
      end else begin
         send_ff <= nxt_send;
         tx_idx_ff <= nxt_tx_idx;
         tx_ff <= nxt_tx;
      end
   end

   // Outputs come straight from registers
   assign tx = tx_ff;
   assign busy = send_ff;
   assign card_state = st_ff;
endmodule
`default_nettype wire

// [dv/atqb_responder_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module atqb_responder_properties (
   input wire logic clk,
   input wire logic rst,
   input wire atqb_pkg::rx_byte_s rx,
   input wire logic tx_ready,
   input wire logic [3:0] fwi,
   input wire logic halt_req,
   input wire atqb_pkg::tx_byte_s tx,
   input wire logic busy,
   input wire logic [1:0] card_state
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Answers start only after a good final byte
   property p_go; $rose(busy) |-> $past(rx.eof) && $past(rx.crc_ok); endproperty
   a_go: assert property (p_go) else $error("busy with no frame");
   property p_rdy; $rose(busy) |-> card_state == 2'b01; endproperty
   a_rdy: assert property (p_rdy) else $error("not ready");
   property p_hlt; halt_req |=> card_state == 2'b10; endproperty
   a_hlt: assert property (p_hlt) else $error("not halted");
   property p_hdr; $rose(busy) |=> tx.valid && tx.data == 8'h50; endproperty
   a_hdr: assert property (p_hdr) else $error("bad first byte");
   // A stalled byte must not move
   property p_hold; tx.valid && !tx_ready |=> $stable(tx); endproperty
   a_hold: assert property (p_hold) else $error("byte moved");
   property p_end; tx.valid && tx.last |-> !busy; endproperty
   a_end: assert property (p_end) else $error("busy at end");
   property p_fw; tx.valid && tx.last |-> tx.data == {fwi, 4'h0}; endproperty
   a_fw: assert property (p_fw) else $error("bad third info");
   property p_inf;
      tx.valid && tx.last && $past(tx_ready) && $past(tx_ready, 2)
         |-> $past(tx.data) == 8'h81 && $past(tx.data, 2) == 8'h91;
   endproperty
   a_inf: assert property (p_inf) else $error("bad info bytes");
   c_ans: cover property ($rose(busy));
   c_stall: cover property (tx.valid && !tx_ready);
   c_wake: cover property ($past(card_state) == 2'b10 && $rose(busy));
endmodule
bind atqb_responder atqb_responder_properties u_props (.clk, .rst, .rx, .tx_ready, .fwi,
   .halt_req, .tx, .busy, .card_state);
`default_nettype wire

// [dv/atqb_reader.sv]
`timescale 1ns/1ps
`default_nettype none
module atqb_reader #(
   parameter int GUARD = 1321
) (
   input wire logic clk,
   input wire logic slow,
   input wire atqb_pkg::tx_byte_s tx,
   output atqb_pkg::rx_byte_s rx,
   output logic tx_ready
);
   logic [7:0] got[$];
   int last_pos = -1;
   logic ph = 1'b0;
   initial rx = '0;
   // Slow mode drops ready every other cycle
   assign tx_ready = !slow || ph;
   always @(posedge clk) begin
      ph <= !ph;
      if (tx.valid && tx_ready) begin
         if (tx.last) last_pos = got.size();
         got.push_back(tx.data);
      end
   end
   // Guard wait first, since a card may still be talking
   task automatic send(logic [7:0] cmd, afi, prm, logic ok);
      logic [7:0] b[5];
      b = '{cmd, afi, prm, 8'h3c, 8'hc3};
      repeat (GUARD) @(posedge clk);
      got.delete();
      last_pos = -1;
      for (int i = 0; i < 5; i++) begin
         #1 rx = '{1'b1, i == 0, i == 4, ok, b[i]};
         @(posedge clk);
      end
      #1 rx = '{1'b0, 1'b0, 1'b0, 1'b0, ~b[4]};
   endtask
endmodule
`default_nettype wire

// [dv/reqb_wupb_atqb_responder_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module reqb_wupb_atqb_responder_bench;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic halt_req = 1'b0;
   logic slow = 1'b0;
   logic [3:0] fwi = 4'h0;
   logic [31:0] card_id = 32'hc3a5_1e7f;
   atqb_pkg::rx_byte_s rx;
   atqb_pkg::tx_byte_s tx;
   logic tx_ready, busy;
   logic [1:0] card_state;
   int errors = 0, total_checks = 0;
   // Rows: family byte, parameter byte, answer expected
   logic [19:0] rows[10] = '{20'h00001, 20'h30011, 20'h0a021, 20'h3a031, 20'h3b040,
      20'h4a050, 20'h3ae61, 20'h3a171, 20'h3a0f1, 20'h50000};
   always #50 clk = ~clk;
   atqb_responder #(.FAMILY(8'h3a)) u_dut (.clk, .rst, .rx, .tx_ready, .card_id, .fwi,
      .halt_req, .tx, .busy, .card_state);
   atqb_reader u_rdr (.clk, .slow, .tx, .rx, .tx_ready);
   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      total_checks++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask
   task automatic stop_test;
      $display("errors %0d checks %0d", errors, total_checks);
      if (errors == 0 && total_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Sends one frame, then compares the whole answer
   task automatic frame(logic [7:0] cmd, afi, prm, logic ok, ans);
      logic [95:0] e;
      int k;
      e = {8'h50, card_id, 32'h0, 8'h91, 8'h81, fwi, 4'h0};
      u_rdr.send(cmd, afi, prm, ok);
      for (k = 0; k < 60 && u_rdr.got.size() < 12; k++) @(posedge clk);
      #1 check("count", u_rdr.got.size(), ans ? 12 : 0);
      check("last", u_rdr.last_pos, ans ? 11 : -1);
      for (int j = 0; ans && j < u_rdr.got.size(); j++)
         check("byte", u_rdr.got[j], e[95 - 8 * j -: 8]);
      if (ans && k == 60) stop_test();
   endtask
   // Reset first, the table next, the awkward cases after
   initial begin
      repeat (20) @(posedge clk);
      #1 rst = 1'b0;
      check("reset", {busy, card_state, tx}, 0);
      for (int i = 0; i < 10; i++) begin
         fwi = i[3:0];
         frame(8'h05, rows[i][19:12], rows[i][11:4], 1'b1, rows[i][0]);
      end
      frame(8'h06, 8'h3a, 8'h00, 1'b1, 1'b0);
      frame(8'h05, 8'h3a, 8'h00, 1'b0, 1'b0);
      slow = 1'b1;
      frame(8'h05, 8'h3a, 8'h08, 1'b1, 1'b1);
      slow = 1'b0;
      halt_req = 1'b1;
      @(posedge clk);
      #1 halt_req = 1'b0;
      check("halt", card_state, 2);
      frame(8'h05, 8'h3a, 8'h00, 1'b1, 1'b0);
      frame(8'h05, 8'h3a, 8'h08, 1'b1, 1'b1);
      check("wake", card_state, 1);
      stop_test();
   end
endmodule
`default_nettype wire
